/* File: hdl/plr_regs.svh */
// Purpose: register offsets, field positions, reset values and duty thresholds for pin level readback
// Assumes: Avalon-MM byte addressing with one 16-bit register per 32-bit word
// Notes:   definitions only
`ifndef PLR_REGS_SVH
`define PLR_REGS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define PLR_IDX_PRIMARY 4'h7
`define PLR_IDX_AUX 4'h8
`define PLR_IDX_WINDOW 4'h9
`define PLR_ADDR_PRIMARY 8'h1C
`define PLR_ADDR_AUX 8'h20
`define PLR_ADDR_WINDOW 8'h24

// ----------------------------------------
// Field positions (low bit of each code)
// ----------------------------------------
`define PLR_POS_PIN0 0
`define PLR_POS_PIN1 2
`define PLR_POS_PIN2 4
`define PLR_POS_PIN3 6
`define PLR_POS_PIN4 8
`define PLR_POS_B0 0
`define PLR_POS_B1 2
`define PLR_POS_A0 8
`define PLR_POS_A1 10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PLR_RST_CODES 16'h0000
`define PLR_RST_WINDOW 16'h0100

// ----------------------------------------
// Duty thresholds, in thousandths of the window
// ----------------------------------------
`define PLR_STRONG_PERMILLE 666
`define PLR_HALF_PERMILLE 500
`define PLR_PERMILLE 1000

`endif

/* File: hdl/plr_pkg.sv */
// Purpose: types for pin level readback
// Assumes: nothing
// Notes:   constants live in plr_regs.svh
package plr_pkg;

  // ----------------------------------------
  // Level codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PLR_LOW = 2'h0,
    PLR_WEAK_LOW = 2'h1,
    PLR_WEAK_HIGH = 2'h2,
    PLR_HIGH = 2'h3
  } plr_code_t;

  // ----------------------------------------
  // Bus answer states, Gray along the read path
  // ----------------------------------------
  typedef enum logic [1:0] {
    PLR_IDLE = 2'h0,
    PLR_ANSWER = 2'h1
  } plr_bus_t;

endpackage

/* File: hdl/plr_top.sv */
// Purpose: pin level readback for nine general-purpose pins over Avalon-MM
// Assumes: sys_clk 40 MHz, rst synchronous active high, pins asynchronous
// Notes:   each pin is measured over a window of sys_clk cycles set by software
//
// How it works
// - pins 4..0 codes sit in primary register bits 9:8 down to 1:0.
// - aux 1A, 0A, 1B, 0B codes sit in bits 11:10, 9:8, 3:2, 1:0.
// - code 00 when static low or low portion above 66.6 percent.
// - code 01 when low portion from 50 to 66.6 percent inclusive.
// - code 10 when high portion above 50 up to 66.6 percent.
// - code 11 when static high or high portion above 66.6 percent.
// - codes follow the sampled pin whatever its direction setting.
// - primary register bits 15:10 always read zero.
`include "plr_regs.svh"

module plr_top #(
  parameter int NPINS = 9,
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins, index 0..4 = pin0..pin4, 5 = b0, 6 = b1, 7 = a0, 8 = a1
  input wire logic [NPINS-1:0] pin_level,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [NPINS-1:0] sync1;
  logic [NPINS-1:0] sync2;
  logic [NPINS-1:0] sync3;
  logic [NPINS-1:0] level;
  logic [CW-1:0] window_len;
  logic [CW-1:0] win_cnt;
  logic win_end;
  logic [CW-1:0] high_cnt [NPINS];
  logic [1:0] code [NPINS];
  logic [15:0] primary_pin_level_codes;
  logic [15:0] aux_pin_level_codes;
  plr_pkg::plr_bus_t bus_state;
  logic [31:0] next_readdata;
  logic next_err;

  // Classify high time against the window; thresholds in thousandths
  function automatic plr_pkg::plr_code_t classify(input logic [CW-1:0] hi,
                                                  input logic [CW-1:0] len);
    logic [CW+10:0] h;
    logic [CW+10:0] l;
    h = (CW+11)'(hi) * (CW+11)'(`PLR_PERMILLE);
    l = ((CW+11)'(len) - (CW+11)'(hi)) * (CW+11)'(`PLR_PERMILLE);
    if (h > (CW+11)'(len) * (CW+11)'(`PLR_STRONG_PERMILLE))
      classify = plr_pkg::PLR_HIGH;
    else if (l > (CW+11)'(len) * (CW+11)'(`PLR_STRONG_PERMILLE))
      classify = plr_pkg::PLR_LOW;
    else if (h > (CW+11)'(len) * (CW+11)'(`PLR_HALF_PERMILLE))
      classify = plr_pkg::PLR_WEAK_HIGH;
    else
      classify = plr_pkg::PLR_WEAK_LOW;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Sampling the pad, not the output driver, keeps outputs and inputs alike
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      level <= '0;
    end else begin
      sync1 <= pin_level;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= (sync2 & sync3) | (level & (sync2 | sync3));
    end
  end

  // ----------------------------------------
  // Measurement window
  // ----------------------------------------
  assign win_end = (win_cnt >= window_len - CW'(1));

  always_ff @(posedge sys_clk) begin
    if (rst)
      win_cnt <= '0;
    else if (win_end)
      win_cnt <= '0;
    else
      win_cnt <= win_cnt + CW'(1);
  end

  // ----------------------------------------
  // Per-pin high counters and codes
  // ----------------------------------------
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        high_cnt[i] <= '0;
        code[i] <= 2'h0;
      end else if (win_end) begin
        code[i] <= classify(high_cnt[i] + CW'(level[i]), window_len);
        high_cnt[i] <= '0;
      end else begin
        high_cnt[i] <= high_cnt[i] + CW'(level[i]);
      end
    end
  end

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  // Reserved bits are tied to zero; no bus write reaches these images
  always_comb begin
    primary_pin_level_codes = `PLR_RST_CODES;
    primary_pin_level_codes[`PLR_POS_PIN0 +: 2] = code[0];
    primary_pin_level_codes[`PLR_POS_PIN1 +: 2] = code[1];
    primary_pin_level_codes[`PLR_POS_PIN2 +: 2] = code[2];
    primary_pin_level_codes[`PLR_POS_PIN3 +: 2] = code[3];
    primary_pin_level_codes[`PLR_POS_PIN4 +: 2] = code[4];
    aux_pin_level_codes = `PLR_RST_CODES;
    aux_pin_level_codes[`PLR_POS_B0 +: 2] = code[5];
    aux_pin_level_codes[`PLR_POS_B1 +: 2] = code[6];
    aux_pin_level_codes[`PLR_POS_A0 +: 2] = code[7];
    aux_pin_level_codes[`PLR_POS_A1 +: 2] = code[8];
  end

  // ----------------------------------------
  // Window length register
  // ----------------------------------------
  // Lengths below two cycles cannot resolve duty, so they are refused
  // Write lands at the edge where the master sees waitrequest low
  always_ff @(posedge sys_clk) begin
    if (rst)
      window_len <= CW'(`PLR_RST_WINDOW);
    else if (bus_state == plr_pkg::PLR_ANSWER && avs_write && avs_address == `PLR_ADDR_WINDOW
             && avs_byteenable[1:0] == 2'h3 && avs_writedata[CW-1:0] > CW'(1))
      window_len <= avs_writedata[CW-1:0];
  end

  // ----------------------------------------
  // Avalon-MM answer
  // ----------------------------------------
  always_comb begin
    next_readdata = 32'h0000_0000;
    next_err = 1'b0;
    case (avs_address)
      `PLR_ADDR_PRIMARY: next_readdata = {16'h0000, primary_pin_level_codes};
      `PLR_ADDR_AUX: next_readdata = {16'h0000, aux_pin_level_codes};
      `PLR_ADDR_WINDOW: next_readdata = {{(32-CW){1'b0}}, window_len};
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_state <= plr_pkg::PLR_IDLE;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else begin
      case (bus_state)
        plr_pkg::PLR_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= plr_pkg::PLR_ANSWER;
            avs_readdata <= avs_read ? next_readdata : 32'h0000_0000;
            avs_response <= next_err ? 2'h3 : 2'h0;
          end
        end
        plr_pkg::PLR_ANSWER: bus_state <= plr_pkg::PLR_IDLE;
        default: bus_state <= plr_pkg::PLR_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && bus_state != plr_pkg::PLR_ANSWER;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_prim_reserved;
    @(posedge sys_clk) disable iff (rst)
      primary_pin_level_codes[15:10] == 6'h00;
  endproperty
  a_prim_reserved: assert property (p_prim_reserved) else $error("primary reserved set");

  property p_aux_reserved;
    @(posedge sys_clk) disable iff (rst)
      aux_pin_level_codes[15:12] == 4'h0 && aux_pin_level_codes[7:4] == 4'h0;
  endproperty
  a_aux_reserved: assert property (p_aux_reserved) else $error("aux reserved set");

  property p_pin4_field;
    @(posedge sys_clk) disable iff (rst)
      primary_pin_level_codes[9:8] == code[4] && primary_pin_level_codes[1:0] == code[0];
  endproperty
  a_pin4_field: assert property (p_pin4_field) else $error("primary field wrong");

  property p_aux_field;
    @(posedge sys_clk) disable iff (rst)
      aux_pin_level_codes[11:10] == code[8] && aux_pin_level_codes[1:0] == code[5];
  endproperty
  a_aux_field: assert property (p_aux_field) else $error("aux field wrong");

  property p_static_high;
    @(posedge sys_clk) disable iff (rst)
      win_end && high_cnt[0] == window_len - CW'(1) && level[0] |=> code[0] == 2'h3;
  endproperty
  a_static_high: assert property (p_static_high) else $error("static high not 11");

  property p_static_low;
    @(posedge sys_clk) disable iff (rst)
      win_end && high_cnt[0] == '0 && !level[0] |=> code[0] == 2'h0;
  endproperty
  a_static_low: assert property (p_static_low) else $error("static low not 00");

  property p_half_weak_low;
    @(posedge sys_clk) disable iff (rst)
      win_end && !window_len[0] && high_cnt[3] + CW'(level[3]) == window_len >> 1
        |=> code[3] == 2'h1;
  endproperty
  a_half_weak_low: assert property (p_half_weak_low) else $error("half duty not 01");

  property p_weak_high;
    @(posedge sys_clk) disable iff (rst)
      win_end && window_len == CW'(10) && high_cnt[4] + CW'(level[4]) == CW'(6)
        |=> code[4] == 2'h2;
  endproperty
  a_weak_high: assert property (p_weak_high) else $error("60 percent not 10");

  property p_hold;
    @(posedge sys_clk) disable iff (rst)
      !win_end |=> $stable(primary_pin_level_codes) && $stable(aux_pin_level_codes);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved off window edge");

  property p_follow_pin;
    @(posedge sys_clk) disable iff (rst)
      sync2[3] && sync3[3] |=> level[3];
  endproperty
  a_follow_pin: assert property (p_follow_pin) else $error("level missed pin");

endmodule

/* File: testbench/plr_pin_model.sv */
// Purpose: PWM source standing in for one external pin
// Assumes: period of 10 sys_clk cycles, high for the first duty cycles
// Notes:   duty 0 and 10 give static low and static high
module plr_pin_model (
  // Clock
  input wire logic sys_clk,
  // High cycles per period
  input wire logic [3:0] duty,
  // Pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] phase = 4'h0;

  // Period equals the test window, so any window alignment sees duty high cycles
  always @(posedge sys_clk) begin
    phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
  end

  assign pin = (phase < duty);
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for pin level readback
// Assumes: Avalon-MM access with waitrequest, window set to 10 cycles
// Notes:   nine PWM models drive the pins
`include "plr_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  wire logic [8:0] pin_level;
  logic [7:0] avs_address = 8'h00;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [3:0] duty [9] = '{default: 4'hA};
  logic [3:0] tab [2][9] = '{'{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'h6, 4'h4},
    '{4'hA, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h0, 4'h5, 4'h7}};
  logic [31:0] exp_p, exp_a, d;
  logic [1:0] r;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  plr_top DUT (.sys_clk(sys_clk), .rst(rst), .pin_level(pin_level),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response));

  for (genvar g = 0; g < 9; g++) begin : g_pin
    plr_pin_model PIN (.sys_clk(sys_clk), .duty(duty[g]), .pin(pin_level[g]));
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      finish_test;
    end
  end

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge, takes data there
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20) chk("waitrequest", 32'h0, 32'h1);
    d = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Thresholds for a 10-cycle window, 66.6 percent taken as 666/1000
  function automatic logic [1:0] code_of(input int h);
    if (h * 1000 > 6660) return 2'h3;
    if ((10 - h) * 1000 > 6660) return 2'h0;
    if (h * 1000 > 5000) return 2'h2;
    return 2'h1;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    xfer(1'b0, `PLR_ADDR_PRIMARY, 32'h0);
    chk("primary reset", 32'h0, d);
    xfer(1'b0, `PLR_ADDR_AUX, 32'h0);
    chk("aux reset", 32'h0, d);
    chk("aux response", 32'h0, {30'h0, r});
    xfer(1'b0, `PLR_ADDR_WINDOW, 32'h0);
    chk("window reset", 32'h100, d);
    xfer(1'b0, 8'h30, 32'h0);
    chk("unmapped data", 32'h0, d);
    chk("unmapped response", 32'h3, {30'h0, r});
    xfer(1'b1, `PLR_ADDR_WINDOW, 32'hA);
    xfer(1'b0, `PLR_ADDR_WINDOW, 32'h0);
    chk("window", 32'hA, d);
    // Window writes without the low bytes, or below two cycles, are refused
    @(posedge sys_clk);
    avs_byteenable <= 4'hC;
    xfer(1'b1, `PLR_ADDR_WINDOW, 32'h4);
    @(posedge sys_clk);
    avs_byteenable <= 4'hF;
    xfer(1'b1, `PLR_ADDR_WINDOW, 32'h1);
    xfer(1'b0, `PLR_ADDR_WINDOW, 32'h0);
    chk("window refused", 32'hA, d);
  endtask

  task t_codes(input int t);
    logic [1:0] c [9];
    @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      duty[i] <= tab[t][i];
      c[i] = code_of(tab[t][i]);
    end
    // Four full windows, which also covers the synchroniser delay
    repeat (40) @(posedge sys_clk);
    exp_p = {22'h0, c[4], c[3], c[2], c[1], c[0]};
    exp_a = {20'h0, c[8], c[7], 4'h0, c[6], c[5]};
    xfer(1'b0, `PLR_ADDR_PRIMARY, 32'h0);
    chk("primary codes", exp_p, d);
    xfer(1'b0, `PLR_ADDR_AUX, 32'h0);
    chk("aux codes", exp_a, d);
  endtask

  task t_write_ignored;
    xfer(1'b1, `PLR_ADDR_PRIMARY, 32'hFFFF);
    chk("write response", 32'h0, {30'h0, r});
    xfer(1'b1, `PLR_ADDR_AUX, 32'hFFFF);
    xfer(1'b0, `PLR_ADDR_PRIMARY, 32'h0);
    chk("primary after write", exp_p, d);
    xfer(1'b0, `PLR_ADDR_AUX, 32'h0);
    chk("aux after write", exp_a, d);
  endtask

  // Reset in mid-run clears measured codes and returns the window length to 0x100
  task t_mid_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    xfer(1'b0, `PLR_ADDR_PRIMARY, 32'h0);
    chk("primary mid reset", 32'h0, d);
    xfer(1'b0, `PLR_ADDR_AUX, 32'h0);
    chk("aux mid reset", 32'h0, d);
    xfer(1'b0, `PLR_ADDR_WINDOW, 32'h0);
    chk("window mid reset", 32'h100, d);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_codes(0);
    t_codes(1);
    t_write_ignored;
    t_mid_reset;
    finish_test;
  end
endmodule
